// ===== verilog/hpds_defs.vh
`ifndef HPDS_DEFS_VH
`define HPDS_DEFS_VH

// register addresses (8-bit register address on the control port)
`define HPDS_ADDR_STATUS 8'h58
`define HPDS_ADDR_RIGHT_RB 8'h59
`define HPDS_ADDR_LEFT_RB 8'h5A
`define HPDS_ADDR_STAGE 8'h60

// status field positions
`define HPDS_ANY_DONE_LSB 8
`define HPDS_WR_DONE_LSB 4
`define HPDS_SU_DONE_LSB 0

// stage control bit positions
`define HPDS_L_SHORT_BIT 7
`define HPDS_L_OUTP_BIT 6
`define HPDS_L_INTER_BIT 5
`define HPDS_R_SHORT_BIT 3
`define HPDS_R_OUTP_BIT 2
`define HPDS_R_INTER_BIT 1

// reset values
`define HPDS_STAGE_RESET 16'h0000
`define HPDS_OFFSET_RESET 8'h00

// offset step in microvolts, and readback range limits in steps
`define HPDS_OFFSET_STEP_UV 250
`define HPDS_OFFSET_MIN 8'h80
`define HPDS_OFFSET_MAX 8'h7F

`endif

// ===== verilog/hpds_servo_channel.v
`timescale 1ns/1ps
`include "hpds_defs.vh"

module hpds_servo_channel (
  clk,
  rst_n,
  wr_done_pulse,
  su_done_pulse,
  applied_value,
  offset_value,
  wr_done,
  su_done
);
  input wire clk;
  input wire rst_n;
  input wire wr_done_pulse;
  input wire su_done_pulse;
  input wire [7:0] applied_value;
  output reg [7:0] offset_value;
  output reg wr_done;
  output reg su_done;

  // value and flag update in the same edge so software never sees a stale pair
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      offset_value <= `HPDS_OFFSET_RESET; // R4
      wr_done <= 1'h0;
      su_done <= 1'h0;
    end else begin
      if (wr_done_pulse || su_done_pulse) begin
        offset_value <= applied_value; // R15 R16
      end
      if (wr_done_pulse) begin
        wr_done <= 1'h1; // R2
      end
      if (su_done_pulse) begin
        su_done <= 1'h1; // R3 R14
      end
    end
  end
endmodule // hpds_servo_channel

// ===== verilog/hpds_stage_regs.v
`timescale 1ns/1ps
`include "hpds_defs.vh"

// Behaviour
// R1 - any_correction_done bits 9:8 are OR of write and startup done, right in bit 1.
// R2 - write_correction_done bits 5:4 set when write correction finishes, right in bit 1.
// R3 - startup_correction_done bits 1:0 set when startup correction finishes, right bit 1.
// R4 - right offset readback is read-only 8 bits in 7:0, reset zero.
// R5 - left offset readback is read-only 8 bits in 7:0, reset zero.
// R6 - readback values are signed two's complement, 0.25mV step, -32 to +31.75mV.
// R7 - short held while short-release bit is 0; left bit 7, right bit 3.
// R8 - host sets short-release only after that channel's output stage is on.
// R9 - output stage on follows its bit; left bit 6, right bit 2.
// R10 - host sets output stage only after that channel's offset correction completes.
// R11 - intermediate stage on follows its bit; left bit 5, right bit 1.
// R12 - host sets intermediate stage at least 20us after that channel's headphone enable.
// R13 - all short-release, output-stage and intermediate-stage bits reset to 0.
// R14 - writing startup trigger launches startup correction; trigger reads 1 while running. No trigger bit here, startup done pulse only latched.
// R15 - write mode applies host 8-bit two's complement offset, 0.25mV per step.
// R16 - readback takes applied value when correction completes, flag set same update.
module hpds_stage_regs (
  clk,
  resetn,
  reg_addr,
  reg_wdata,
  reg_wr,
  reg_rd,
  reg_rdata,
  left_wr_done_pulse,
  right_wr_done_pulse,
  left_su_done_pulse,
  right_su_done_pulse,
  left_applied_value,
  right_applied_value,
  left_short_release,
  right_short_release,
  left_output_stage_on,
  right_output_stage_on,
  left_intermediate_stage_on,
  right_intermediate_stage_on
);
  input wire clk;
  input wire resetn;
  input wire [7:0] reg_addr;
  input wire [15:0] reg_wdata;
  input wire reg_wr;
  input wire reg_rd;
  output reg [15:0] reg_rdata;
  input wire left_wr_done_pulse;
  input wire right_wr_done_pulse;
  input wire left_su_done_pulse;
  input wire right_su_done_pulse;
  input wire [7:0] left_applied_value;
  input wire [7:0] right_applied_value;
  output reg left_short_release;
  output reg right_short_release;
  output reg left_output_stage_on;
  output reg right_output_stage_on;
  output reg left_intermediate_stage_on;
  output reg right_intermediate_stage_on;

  // ==========================================================
  // reset release
  reg rst_meta_reg;
  reg rst_sync_reg;
  wire rst_n;

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rst_meta_reg <= 1'h0;
      rst_sync_reg <= 1'h0;
    end else begin
      rst_meta_reg <= 1'h1;
      rst_sync_reg <= rst_meta_reg;
    end
  end
  // assert is immediate, release waits two edges so no flop leaves reset on a late edge
  assign rst_n = rst_sync_reg;

  // ==========================================================
  // servo readback channels
  wire [7:0] left_offset_value_readback;
  wire [7:0] right_offset_value_readback;
  wire [1:0] write_correction_done;
  wire [1:0] startup_correction_done;
  wire [1:0] any_correction_done;

  hpds_servo_channel u_left (
    .clk(clk),
    .rst_n(rst_n),
    .wr_done_pulse(left_wr_done_pulse),
    .su_done_pulse(left_su_done_pulse),
    .applied_value(left_applied_value),
    .offset_value(left_offset_value_readback), // R5
    .wr_done(write_correction_done[0]),
    .su_done(startup_correction_done[0])
  );

  hpds_servo_channel u_right (
    .clk(clk),
    .rst_n(rst_n),
    .wr_done_pulse(right_wr_done_pulse),
    .su_done_pulse(right_su_done_pulse),
    .applied_value(right_applied_value),
    .offset_value(right_offset_value_readback), // R4
    .wr_done(write_correction_done[1]),
    .su_done(startup_correction_done[1])
  );

  assign any_correction_done = write_correction_done | startup_correction_done; // R1

  // ==========================================================
  // status word, bit 1 of each pair is the right channel
  // flags are sticky: nothing short of reset clears them
  reg [15:0] status_word;

  always @* begin
    status_word = 16'h0000;
    status_word[`HPDS_ANY_DONE_LSB +: 2] = any_correction_done; // R1
    status_word[`HPDS_WR_DONE_LSB +: 2] = write_correction_done; // R2
    status_word[`HPDS_SU_DONE_LSB +: 2] = startup_correction_done; // R3
  end

  // ==========================================================
  // stage control register
  reg [15:0] stage_reg;
  reg [15:0] stage_next;
  wire stage_write;

  // only the six documented bits are storable; the rest read zero
  function [15:0] stage_mask;
    input [15:0] d;
    begin
      stage_mask = 16'h0000;
      stage_mask[`HPDS_L_SHORT_BIT] = d[`HPDS_L_SHORT_BIT];
      stage_mask[`HPDS_L_OUTP_BIT] = d[`HPDS_L_OUTP_BIT];
      stage_mask[`HPDS_L_INTER_BIT] = d[`HPDS_L_INTER_BIT];
      stage_mask[`HPDS_R_SHORT_BIT] = d[`HPDS_R_SHORT_BIT];
      stage_mask[`HPDS_R_OUTP_BIT] = d[`HPDS_R_OUTP_BIT];
      stage_mask[`HPDS_R_INTER_BIT] = d[`HPDS_R_INTER_BIT];
    end
  endfunction

  // writes to the status and readback words fall through here and are dropped
  assign stage_write = reg_wr && (reg_addr == `HPDS_ADDR_STAGE);

  always @* begin
    stage_next = stage_reg;
    if (stage_write) begin
      // no sequencing interlock: ordering is left to the host, a wrong order only risks a pop
      stage_next = stage_mask(reg_wdata); // R8 R10 R12
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stage_reg <= `HPDS_STAGE_RESET; // R13
    end else begin
      stage_reg <= stage_next;
    end
  end

  // ==========================================================
  // stage drives
  // fed from stage_next so the pins move on the same edge as the register
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      left_short_release <= 1'h0; // R13
      left_output_stage_on <= 1'h0; // R13
      left_intermediate_stage_on <= 1'h0; // R13
    end else begin
      left_short_release <= stage_next[`HPDS_L_SHORT_BIT]; // R7
      left_output_stage_on <= stage_next[`HPDS_L_OUTP_BIT]; // R9
      left_intermediate_stage_on <= stage_next[`HPDS_L_INTER_BIT]; // R11
    end
  end

  // right channel mirrors the left, its own flops keep the pins independent
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      right_short_release <= 1'h0; // R13
      right_output_stage_on <= 1'h0; // R13
      right_intermediate_stage_on <= 1'h0; // R13
    end else begin
      right_short_release <= stage_next[`HPDS_R_SHORT_BIT]; // R7
      right_output_stage_on <= stage_next[`HPDS_R_OUTP_BIT]; // R9
      right_intermediate_stage_on <= stage_next[`HPDS_R_INTER_BIT]; // R11
    end
  end

  // ==========================================================
  // readback mux, registered one cycle after reg_rd
  reg [15:0] rdata_next;

  // raw two's complement byte, sign not extended into the upper bits
  function [15:0] offset_word;
    input [7:0] v;
    begin
      offset_word = {8'h00, v};
    end
  endfunction

  always @* begin
    rdata_next = 16'h0000;
    case (reg_addr)
      `HPDS_ADDR_STATUS: rdata_next = status_word; // R1 R2 R3
      `HPDS_ADDR_RIGHT_RB: rdata_next = offset_word(right_offset_value_readback); // R4 R6
      `HPDS_ADDR_LEFT_RB: rdata_next = offset_word(left_offset_value_readback); // R5 R6
      `HPDS_ADDR_STAGE: rdata_next = stage_reg;
      default: rdata_next = 16'h0000;
    endcase
  end

  // word holds until the next read so a slow serial slave can shift it out at leisure
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      reg_rdata <= rdata_next;
    end
  end
endmodule // hpds_stage_regs

// ===== verification/hpds_stage_props.sv
`timescale 1ns/1ps
module hpds_stage_props (
  input wire clk, resetn, reg_wr, reg_rd,
  input wire [7:0] reg_addr,
  input wire [15:0] reg_wdata, reg_rdata,
  input wire left_wr_done_pulse, right_wr_done_pulse, left_su_done_pulse, right_su_done_pulse,
  input wire [7:0] left_applied_value, right_applied_value,
  input wire left_short_release, right_short_release, left_output_stage_on, right_output_stage_on,
  input wire left_intermediate_stage_on, right_intermediate_stage_on
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  wire [7:0] st = {left_short_release, left_output_stage_on, left_intermediate_stage_on, 1'h0,
    right_short_release, right_output_stage_on, right_intermediate_stage_on, 1'h0};
  wire wst = reg_wr && reg_addr == 8'h60;
  wire [7:0] a = reg_addr;
  sequence s_rsu; right_su_done_pulse ##1 (reg_rd && a == 8'h59); endsequence
  sequence s_lwr; left_wr_done_pulse ##1 (reg_rd && a == 8'h58); endsequence
  property p_stage; wst |=> st == ($past(reg_wdata[7:0]) & 8'hEE); endproperty
  property p_hold; !wst |=> $stable(st); endproperty
  property p_rd60; reg_rd && !reg_wr && a == 8'h60 |=> reg_rdata == {8'h00, $past(st)}; endproperty
  property p_unm; reg_rd && a != 8'h58 && a != 8'h59 && a != 8'h5A && a != 8'h60 |=> reg_rdata == 16'h0000;
  endproperty
  property p_stand; !reg_rd |=> $stable(reg_rdata); endproperty
  property p_stat; reg_rd && a == 8'h58 |=> (reg_rdata & 16'hFCCC) == 16'h0000 &&
    reg_rdata[9:8] == (reg_rdata[5:4] | reg_rdata[1:0]); endproperty
  property p_rsu; s_rsu |=> reg_rdata == {8'h00, $past(right_applied_value, 2)}; endproperty
  property p_lwr; s_lwr |=> reg_rdata[4] && reg_rdata[8]; endproperty
  a_stage: assert property (p_stage) else $error("stage outputs differ from written bits");
  a_hold: assert property (p_hold) else $error("stage outputs moved without a write");
  a_rd60: assert property (p_rd60) else $error("stage readback wrong");
  a_unm: assert property (p_unm) else $error("unmapped read not zero");
  a_stand: assert property (p_stand) else $error("read data changed without a read");
  a_stat: assert property (p_stat) else $error("status layout wrong");
  a_rsu: assert property (p_rsu) else $error("right readback not applied value");
  a_lwr: assert property (p_lwr) else $error("left write done flag missing");
endmodule // hpds_stage_props
bind hpds_stage_regs hpds_stage_props u_props (.clk, .resetn, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
  .reg_rdata, .left_wr_done_pulse, .right_wr_done_pulse, .left_su_done_pulse, .right_su_done_pulse,
  .left_applied_value, .right_applied_value, .left_short_release, .right_short_release,
  .left_output_stage_on, .right_output_stage_on, .left_intermediate_stage_on, .right_intermediate_stage_on);

// ===== verification/hpds_servo_model.sv
`timescale 1ns/1ps
module hpds_servo_model (
  input wire clk,
  output reg lwp, rwp, lsp, rsp,
  output reg [7:0] lv, rv
);
  initial begin
    {lwp, rwp, lsp, rsp} = 4'h0;
    {lv, rv} = 16'h5AA5;
  end
  // value only promised while its pulse is high, scrambled after
  task done(input right, input su, input [7:0] v, input integer dly);
    begin
      repeat (dly) @(posedge clk);
      if (right) rv <= v; else lv <= v;
      {lsp, rsp, lwp, rwp} <= {su & !right, su & right, !su & !right, !su & right};
      @(posedge clk);
      {lsp, rsp, lwp, rwp} <= 4'h0;
      if (right) rv <= ~v; else lv <= ~v;
    end
  endtask
endmodule // hpds_servo_model

// ===== verification/hpds_stage_regs_tb_top.sv
`timescale 1ns/1ps
module hpds_stage_regs_tb_top;
  reg clk, resetn, reg_wr, reg_rd;
  reg [7:0] reg_addr;
  reg [15:0] reg_wdata;
  wire [15:0] reg_rdata;
  wire lw, rw, ls, rs;
  wire [7:0] lv, rv;
  wire [5:0] o;
  integer miscompares = 0, n_tests = 0, cyc = 0;
  hpds_servo_model SRV (.clk, .lwp(lw), .rwp(rw), .lsp(ls), .rsp(rs), .lv(lv), .rv(rv));
  hpds_stage_regs DUT (.clk, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .left_wr_done_pulse(lw), .right_wr_done_pulse(rw), .left_su_done_pulse(ls), .right_su_done_pulse(rs),
    .left_applied_value(lv), .right_applied_value(rv), .left_short_release(o[5]), .left_output_stage_on(o[4]),
    .left_intermediate_stage_on(o[3]), .right_short_release(o[2]), .right_output_stage_on(o[1]),
    .right_intermediate_stage_on(o[0]));
  task chk(input [15:0] got, input [15:0] exp);
    begin
      n_tests = n_tests + 1;
      if (got !== exp) begin
        miscompares = miscompares + 1;
        $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task wr(input [7:0] a, input [15:0] d);
    begin
      reg_wr <= 1'h1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'h0;
    end
  endtask
  task rd(input [7:0] a, input [15:0] e);
    begin
      reg_rd <= 1'h1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'h0;
      @(posedge clk);
      chk(reg_rdata, e);
    end
  endtask
  // write stage bits, then readback and pins must agree
  task stg(input [15:0] d, input [7:0] e, input [5:0] p);
    begin
      wr(8'h60, d);
      rd(8'h60, {8'h00, e});
      chk({10'h000, o}, {10'h000, p});
    end
  endtask
  task t_reset;
    begin
      rd(8'h58, 16'h0000);
      rd(8'h59, 16'h0000);
      rd(8'h5A, 16'h0000);
      stg(16'h0000, 8'h00, 6'h00);
    end
  endtask
  task t_servo;
    begin
      SRV.done(1'h1, 1'h1, 8'hF0, 0);
      rd(8'h59, 16'h00F0);
      rd(8'h58, 16'h0202);
      SRV.done(1'h0, 1'h0, 8'h80, 7);
      rd(8'h58, 16'h0312);
      rd(8'h5A, 16'h0080);
      rd(8'h59, 16'h00F0);
    end
  endtask
  task t_stage;
    begin
      repeat (4000) @(posedge clk);
      stg(16'h0022, 8'h22, 6'h09);
      stg(16'h0066, 8'h66, 6'h1B);
      stg(16'h00EE, 8'hEE, 6'h3F);
      stg(16'hFF11, 8'h00, 6'h00);
      stg(16'hFF66, 8'h66, 6'h1B);
      stg(16'hFFFF, 8'hEE, 6'h3F);
      wr(8'h58, 16'hFFFF);
      rd(8'h58, 16'h0312);
      rd(8'h70, 16'h0000);
    end
  endtask
  // reset in mid-run clears sticky flags, readback values and stage drives
  task t_rst2;
    begin
      resetn <= 1'h0;
      repeat (2) @(posedge clk);
      resetn <= 1'h1;
      repeat (3) @(posedge clk);
      chk({10'h000, o}, 16'h0000);
      rd(8'h58, 16'h0000);
      rd(8'h59, 16'h0000);
      rd(8'h5A, 16'h0000);
      rd(8'h60, 16'h0000);
    end
  endtask
  task conclude;
    begin
      if (miscompares == 0 && n_tests > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask
  initial begin
    clk = 1'h0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      miscompares = miscompares + 1;
      conclude;
    end
  end
  initial begin
    {resetn, reg_wr, reg_rd, reg_addr, reg_wdata} = 27'h0;
    repeat (5) @(posedge clk);
    resetn <= 1'h1;
    repeat (3) @(posedge clk);
    t_reset;
    t_servo;
    t_stage;
    t_rst2;
    conclude;
  end
endmodule // hpds_stage_regs_tb_top
